// *** common/gpt_pkg.sv ***
// Package for the combined 32-bit general-purpose timer block
package gpt_pkg;
	localparam logic [2:0] CFG_ONESHOT_PERIODIC = 3'h0;
	localparam logic [2:0] CFG_CLOCK = 3'h1;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [15:0] LOAD_RESET = 16'hffff;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;
	localparam logic [31:0] CLOCK_FIRST_VALUE = 32'h00000001;
	localparam logic [31:0] MATCH_RESET = 32'hffffffff;
	localparam int SLOW_CLOCK_HZ = 32768;
	localparam int TICK_HZ = 1;
	localparam int PRESCALE_EDGES = SLOW_CLOCK_HZ / TICK_HZ;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;

	typedef struct packed {
		logic firstEnableSet;
		logic firstEnableClear;
		logic outputTriggerEnable;
		logic firstDebugStall;
		logic secondDebugStall;
		logic clockModeEnable;
	} gpt_ctl_t;

	typedef struct packed {
		logic timeoutRawFlag;
		logic timeoutMaskedFlag;
		logic clockMatchRawFlag;
		logic clockMatchMaskedFlag;
	} gpt_status_t;
endpackage

// *** rtl/gpt_timer.sv ***
// Combined 32-bit timer: one-shot, periodic and real-time clock counter
// Function
// RULE_01 - Two 16-bit counters combine into one 32-bit timer or clock counter.
// RULE_02 - Conversion triggers of all timer blocks are ORed into one trigger.
// RULE_03 - After reset the block is idle with control state at defaults.
// RULE_04 - Reset sets both counters and both load registers to 0xffff.
// RULE_05 - Reset sets both prescale counters and prescale registers to zero.
// RULE_06 - Config 0 selects one-shot/periodic, config 1 the clock counter.
// RULE_07 - In 32-bit configurations the block acts only as one 32-bit timer.
// RULE_08 - A 32-bit load write splits into first and second load halves.
// RULE_09 - Count read returns second counter high, first counter low.
// RULE_10 - First mode field alone picks one-shot or periodic; second ignored.
// RULE_11 - Enable starts down-count; at zero reload; one-shot stops, clears enable.
// RULE_12 - Zero sets raw time-out flag until cleared; masked flag when unmasked.
// RULE_13 - Trigger pulse on time-out only while output trigger enable is set.
// RULE_14 - Load written while counting is taken next cycle, counting continues.
// RULE_15 - With debug stall set, counting freezes while the processor halts.
// RULE_16 - Clock mode counts up; first selection loads one, enable counts on.
// RULE_17 - Software writes later clock load values to the match register.
// RULE_18 - 32.768 kHz input on even capture pin is divided to 1 Hz.
// RULE_19 - Count equal to match rolls over to zero and keeps counting.
// RULE_20 - Match sets raw and masked flags; match clear bit clears both.
// RULE_21 - Clock mode keeps running during debug halt despite stall bits.
// RULE_22 - Input synchronized; 15-bit prescaler gives tick every 32768 edges.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer #(
	parameter int PRESCALE_EDGES = gpt_pkg::PRESCALE_EDGES
) (
	input wire logic core_clk, // System clock, 100 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic [2:0] timerConfig, // Configuration value
	input wire logic [1:0] firstModeField, // First counter mode
	input wire logic [1:0] secondModeField, // Second counter mode, unused here
	input wire gpt_pkg::gpt_ctl_t ctl, // Control bits and enable strobes
	input wire logic loadWrite, // Strobe: 32-bit interval load write
	input wire logic [31:0] loadData, // Interval load write data
	input wire logic matchWrite, // Strobe: match register write
	input wire logic [31:0] matchData, // Match register write data
	input wire logic prescaleWrite, // Strobe: prescale register write
	input wire logic [15:0] prescaleData, // Second:first prescale values
	input wire logic timeoutMask, // Time-out mask, 1 passes
	input wire logic clockMatchMask, // Clock match mask, 1 passes
	input wire logic timeoutClear, // Strobe: clear time-out flags
	input wire logic clockMatchClear, // Strobe: clock match clear bit
	input wire logic cpuHalted, // Processor halted by debugger
	input wire logic capturePwmPinIn, // Even capture pin, slow clock
	input wire logic otherTriggers, // Triggers of the other timer blocks
	output logic firstEnableBit, // First counter enable state
	output logic [31:0] countValue, // Combined count read value
	output logic [31:0] intervalLoad, // Combined load read value
	output logic [15:0] prescaleValue, // Prescale registers read value
	output gpt_pkg::gpt_status_t status, // Raw and masked flags
	output logic timerInt, // Interrupt to processor
	output logic convTrigger // Combined trigger to converter
);
	initial begin
		if (PRESCALE_EDGES < 2 || PRESCALE_EDGES > 32768)
			$error("PRESCALE_EDGES out of range");
	end

	localparam int PW = 15;
	localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE_EDGES - 1);

	typedef enum logic [1:0] {GPT_IDLE, GPT_DOWN, GPT_RTC} gpt_state_t;

	gpt_state_t state_r;
	gpt_state_t state_nxt;
	logic [15:0] firstCount_r;
	logic [15:0] secondCount_r;
	logic [15:0] firstLoad_r;
	logic [15:0] secondLoad_r;
	logic [7:0] firstPrescale_r;
	logic [7:0] secondPrescale_r;
	logic [31:0] match_r;
	logic enable_r;
	logic enable_nxt;
	logic rtcSeen_r;
	logic timeoutRaw_r;
	logic clockRaw_r;
	logic trigger_r;
	logic [1:0] pinSync_r;
	logic pinPrev_r;
	logic [PW-1:0] prescaler_r;
	logic [31:0] count_nxt;

	// Synchroniser and edge counter for the slow input
	wire pinRise = pinSync_r[1] & ~pinPrev_r; // [RULE_22]
	wire prescaleWrap = pinRise && (prescaler_r == PRESCALE_LAST);
	wire secondTick = prescaleWrap; // [RULE_18]

	// Configuration decode; other codes leave the 32-bit counter idle
	wire cfgDown = (timerConfig == gpt_pkg::CFG_ONESHOT_PERIODIC); // [RULE_06]
	wire cfgClock = (timerConfig == gpt_pkg::CFG_CLOCK); // [RULE_06] [RULE_07]
	wire oneShot = (firstModeField == gpt_pkg::MODE_ONESHOT); // [RULE_10]
	wire stalled = cpuHalted && (ctl.firstDebugStall || ctl.secondDebugStall); // [RULE_15]
	wire runStall = stalled && !(cfgClock && ctl.clockModeEnable); // [RULE_21]

	wire [31:0] count32 = {secondCount_r, firstCount_r}; // [RULE_01]
	wire [31:0] load32 = {secondLoad_r, firstLoad_r};
	wire atZero = (count32 == 32'h00000000);
	wire downActive = enable_r && (state_r == GPT_DOWN) && !runStall;
	wire timeoutEvent = downActive && atZero && !loadWrite; // [RULE_11]
	wire rtcActive = enable_r && (state_r == GPT_RTC) && !runStall;
	wire matchEvent = rtcActive && secondTick && (count32 == match_r); // [RULE_19]
	wire enableReq = ctl.firstEnableSet | (enable_r & ~ctl.firstEnableClear);

	always_comb begin
		state_nxt = GPT_IDLE;
		if (cfgDown) begin
			state_nxt = GPT_DOWN;
		end else if (cfgClock) begin
			state_nxt = GPT_RTC;
		end
	end

	// One-shot drops the enable on its time-out
	always_comb begin
		enable_nxt = enableReq;
		if (timeoutEvent && oneShot) begin // [RULE_11]
			enable_nxt = 1'b0;
		end
		if (state_nxt == GPT_IDLE) begin
			enable_nxt = 1'b0;
		end
	end

	// Next count value per mode
	always_comb begin
		count_nxt = count32;
		if (cfgClock && !rtcSeen_r) begin
			count_nxt = gpt_pkg::CLOCK_FIRST_VALUE; // [RULE_16]
		end else if (loadWrite && state_r != GPT_RTC) begin
			count_nxt = loadData; // [RULE_14]
		end else if (timeoutEvent) begin
			count_nxt = load32; // [RULE_11]
		end else if (downActive) begin
			count_nxt = count32 - 32'h00000001;
		end else if (matchEvent) begin
			count_nxt = 32'h00000000; // [RULE_19]
		end else if (rtcActive && secondTick) begin
			count_nxt = count32 + 32'h00000001; // [RULE_16]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pinSync_r <= 2'h0;
			pinPrev_r <= 1'b0;
			prescaler_r <= '0; // [RULE_05]
		end else begin
			pinSync_r <= {pinSync_r[0], capturePwmPinIn}; // [RULE_22]
			pinPrev_r <= pinSync_r[1];
			if (!(cfgClock && enable_r)) begin
				prescaler_r <= '0;
			end else if (prescaleWrap) begin
				prescaler_r <= '0;
			end else if (pinRise) begin
				prescaler_r <= prescaler_r + PW'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= GPT_IDLE; // [RULE_03]
			enable_r <= 1'b0;
			rtcSeen_r <= 1'b0;
			firstCount_r <= gpt_pkg::COUNT_RESET; // [RULE_04]
			secondCount_r <= gpt_pkg::COUNT_RESET;
		end else begin
			state_r <= state_nxt;
			enable_r <= enable_nxt;
			rtcSeen_r <= rtcSeen_r | cfgClock;
			{secondCount_r, firstCount_r} <= count_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			firstLoad_r <= gpt_pkg::LOAD_RESET; // [RULE_04]
			secondLoad_r <= gpt_pkg::LOAD_RESET;
			firstPrescale_r <= gpt_pkg::PRESCALE_RESET; // [RULE_05]
			secondPrescale_r <= gpt_pkg::PRESCALE_RESET;
			match_r <= gpt_pkg::MATCH_RESET;
		end else begin
			if (loadWrite) begin
				{secondLoad_r, firstLoad_r} <= loadData; // [RULE_08]
			end
			if (prescaleWrite) begin
				{secondPrescale_r, firstPrescale_r} <= prescaleData;
			end
			if (matchWrite) begin
				match_r <= matchData; // [RULE_17]
			end
		end
	end

	// Flags: a set in the same cycle as a clear wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			timeoutRaw_r <= 1'b0;
			clockRaw_r <= 1'b0;
			trigger_r <= 1'b0;
		end else begin
			timeoutRaw_r <= timeoutEvent | (timeoutRaw_r & ~timeoutClear); // [RULE_12]
			clockRaw_r <= matchEvent | (clockRaw_r & ~clockMatchClear); // [RULE_20]
			trigger_r <= timeoutEvent & ctl.outputTriggerEnable; // [RULE_13]
		end
	end

	assign firstEnableBit = enable_r;
	assign countValue = count32; // [RULE_09]
	assign intervalLoad = load32;
	assign prescaleValue = {secondPrescale_r, firstPrescale_r};
	assign status.timeoutRawFlag = timeoutRaw_r;
	assign status.timeoutMaskedFlag = timeoutRaw_r & timeoutMask; // [RULE_12]
	assign status.clockMatchRawFlag = clockRaw_r;
	assign status.clockMatchMaskedFlag = clockRaw_r & clockMatchMask; // [RULE_20]
	assign timerInt = status.timeoutMaskedFlag | status.clockMatchMaskedFlag;
	assign convTrigger = trigger_r | otherTriggers; // [RULE_02]
endmodule
`default_nettype wire

// *** sim/gpt_timer_chk.sv ***
// Assertion checker for the combined 32-bit timer ports
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_chk (
	input wire logic core_clk, // Clock
	input wire logic resetn, // Reset
	input wire logic [2:0] timerConfig, // Configuration
	input wire gpt_pkg::gpt_ctl_t ctl, // Control bits
	input wire logic loadWrite, // Load strobe
	input wire logic [31:0] loadData, // Load data
	input wire logic timeoutMask, // Time-out mask
	input wire logic clockMatchMask, // Match mask
	input wire logic timeoutClear, // Time-out clear
	input wire logic cpuHalted, // Debug halt
	input wire logic otherTriggers, // Other triggers
	input wire logic firstEnableBit, // Enable state
	input wire logic [31:0] countValue, // Count
	input wire logic [31:0] intervalLoad, // Load value
	input wire gpt_pkg::gpt_status_t status, // Flags
	input wire logic timerInt, // Interrupt
	input wire logic convTrigger // Converter trigger
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire logic run = timerConfig == 3'h0 && firstEnableBit && !ctl.firstEnableClear && !loadWrite;
	wire logic go = run && !(cpuHalted && (ctl.firstDebugStall || ctl.secondDebugStall));
	wire logic trig = convTrigger && !otherTriggers;
	property p_or; otherTriggers |-> convTrigger; endproperty
	a_or: assert property (p_or) else $error("trigger not passed on");
	property p_trig; trig |-> $past(ctl.outputTriggerEnable) && status.timeoutRawFlag; endproperty
	a_trig: assert property (p_trig) else $error("trigger without time-out");
	property p_pulse; trig |=> !trig; endproperty
	a_pulse: assert property (p_pulse) else $error("trigger longer than a cycle");
	property p_mask; status.timeoutMaskedFlag == (status.timeoutRawFlag && timeoutMask)
		&& status.clockMatchMaskedFlag == (status.clockMatchRawFlag && clockMatchMask)
		&& timerInt == (status.timeoutMaskedFlag || status.clockMatchMaskedFlag); endproperty
	a_mask: assert property (p_mask) else $error("masked flag wrong");
	property p_hold; status.timeoutRawFlag && !timeoutClear |=> status.timeoutRawFlag; endproperty
	a_hold: assert property (p_hold) else $error("time-out flag lost");
	property p_fall; $fell(firstEnableBit) |-> $past(ctl.firstEnableClear)
		|| status.timeoutRawFlag || $past(timerConfig) > 3'h1; endproperty
	a_fall: assert property (p_fall) else $error("enable dropped early");
	property p_down; go && countValue != 32'h0 |=> countValue == $past(countValue) - 32'h1; endproperty
	a_down: assert property (p_down) else $error("no decrement");
	property p_reload; go && countValue == 32'h0
		|=> countValue == $past(intervalLoad) && status.timeoutRawFlag; endproperty
	a_reload: assert property (p_reload) else $error("no reload at zero");
	property p_stall; run && cpuHalted && ctl.firstDebugStall |=> $stable(countValue); endproperty
	a_stall: assert property (p_stall) else $error("count moved in halt");
	property p_load; loadWrite && timerConfig == 3'h0
		|=> intervalLoad == $past(loadData) && countValue == $past(loadData); endproperty
	a_load: assert property (p_load) else $error("load not taken");
	c_timeout: cover property ($rose(status.timeoutRawFlag));
	c_match: cover property ($rose(status.clockMatchRawFlag));
	c_oneshot: cover property ($fell(firstEnableBit) && status.timeoutRawFlag);
endmodule
`default_nettype wire

// *** sim/gpt_slow_clk_model.sv ***
// Slow clock source on the even capture pin for clock mode
`timescale 1ns/1ps
`default_nettype none
module gpt_slow_clk_model (
	input wire logic run, // Clock runs while high
	output logic capturePwmPinIn // Slow clock toward the timer
);
	initial capturePwmPinIn = 1'h0;
	always #15259 if (run) capturePwmPinIn = ~capturePwmPinIn;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the combined 32-bit timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'h0, resetn = 1'h0, loadWrite = 1'h0, matchWrite = 1'h0;
	logic prescaleWrite = 1'h0, timeoutMask = 1'h1, clockMatchMask = 1'h1, timeoutClear = 1'h0;
	logic clockMatchClear = 1'h0, cpuHalted = 1'h0, otherTriggers = 1'h0, slowRun = 1'h0;
	logic [2:0] timerConfig = 3'h0;
	logic [1:0] firstModeField = gpt_pkg::MODE_PERIODIC, secondModeField = gpt_pkg::MODE_ONESHOT;
	gpt_pkg::gpt_ctl_t ctl = '0;
	logic [31:0] loadData = 32'h0, matchData = 32'h0, countValue, intervalLoad, snap;
	logic [15:0] prescaleData = 16'h0, prescaleValue;
	wire logic capturePwmPinIn;
	logic firstEnableBit, timerInt, convTrigger;
	gpt_pkg::gpt_status_t status;
	int numErrors = 0, cmpCount = 0;
	gpt_timer #(.PRESCALE_EDGES(4)) u_dut (
		.core_clk(core_clk),
		.resetn(resetn),
		.timerConfig(timerConfig),
		.firstModeField(firstModeField),
		.secondModeField(secondModeField),
		.ctl(ctl),
		.loadWrite(loadWrite),
		.loadData(loadData),
		.matchWrite(matchWrite),
		.matchData(matchData),
		.prescaleWrite(prescaleWrite),
		.prescaleData(prescaleData),
		.timeoutMask(timeoutMask),
		.clockMatchMask(clockMatchMask),
		.timeoutClear(timeoutClear),
		.clockMatchClear(clockMatchClear),
		.cpuHalted(cpuHalted),
		.capturePwmPinIn(capturePwmPinIn),
		.otherTriggers(otherTriggers),
		.firstEnableBit(firstEnableBit),
		.countValue(countValue),
		.intervalLoad(intervalLoad),
		.prescaleValue(prescaleValue),
		.status(status),
		.timerInt(timerInt),
		.convTrigger(convTrigger)
	);
	gpt_slow_clk_model u_slow (.run(slowRun), .capturePwmPinIn(capturePwmPinIn));
	always #5 core_clk = ~core_clk;
	task automatic finish_test();
		$display("Mismatches %0d, comparisons %0d", numErrors, cmpCount);
		if (numErrors == 0 && cmpCount > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitst(input int b, input int lim);
		int i;
		for (i = 0; i < lim && status[b] !== 1'h1; i++) @(negedge core_clk);
		if (i == lim) begin
			numErrors++;
			finish_test();
		end
	endtask
	task automatic strobe(input logic [31:0] d, input int k);
		{loadData, matchData, prescaleData} = {d, d, d[15:0]};
		case (k)
			0: loadWrite = 1'h1;
			1: matchWrite = 1'h1;
			2: ctl.firstEnableSet = 1'h1;
			3: timeoutClear = 1'h1;
			4: clockMatchClear = 1'h1;
			5: ctl.firstEnableClear = 1'h1;
			default: prescaleWrite = 1'h1;
		endcase
		@(negedge core_clk);
		{loadWrite, matchWrite, timeoutClear, clockMatchClear, prescaleWrite} = '0;
		{ctl.firstEnableSet, ctl.firstEnableClear} = 2'h0;
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		resetn = 1'h1;
		@(negedge core_clk);
		chk(countValue, 32'hffffffff);
		chk(intervalLoad, 32'hffffffff);
		chk({11'h0, prescaleValue, firstEnableBit, status}, 32'h0);
		strobe(32'h0000a55a, 6);
		chk({16'h0, prescaleValue}, 32'h0000a55a);
		strobe(32'habcd1234, 0);
		chk(intervalLoad, 32'habcd1234);
		chk(countValue, 32'habcd1234);
		ctl.outputTriggerEnable = 1'h1;
		strobe(32'h3, 0);
		strobe(32'h0, 2);
		waitst(3, 50);
		chk({26'h0, convTrigger, firstEnableBit, status}, 32'h3c);
		chk(countValue, 32'h3);
		strobe(32'h0, 3);
		chk({31'h0, status.timeoutRawFlag}, 32'h0);
		{cpuHalted, ctl.firstDebugStall} = 2'h3;
		snap = countValue;
		repeat (6) @(negedge core_clk);
		chk(countValue, snap);
		cpuHalted = 1'h0;
		strobe(32'h0, 5);
		chk({31'h0, firstEnableBit}, 32'h0);
		ctl.outputTriggerEnable = 1'h0;
		firstModeField = gpt_pkg::MODE_ONESHOT;
		strobe(32'h0, 3);
		strobe(32'h5, 0);
		strobe(32'h0, 2);
		strobe(32'h2, 0);
		chk(countValue, 32'h2);
		waitst(3, 50);
		chk({26'h0, convTrigger, firstEnableBit, status}, 32'h0c);
		chk(countValue, 32'h2);
		timeoutMask = 1'h0;
		@(negedge core_clk);
		chk({28'h0, status}, 32'h8);
		chk({31'h0, timerInt}, 32'h0);
		timeoutMask = 1'h1;
		otherTriggers = 1'h1;
		@(negedge core_clk);
		chk({31'h0, convTrigger}, 32'h1);
		otherTriggers = 1'h0;
		strobe(32'h0, 3);
		timerConfig = 3'h2;
		strobe(32'h0, 2);
		chk({31'h0, firstEnableBit}, 32'h0);
		timerConfig = gpt_pkg::CFG_CLOCK;
		@(negedge core_clk);
		chk(countValue, gpt_pkg::CLOCK_FIRST_VALUE);
		{ctl.clockModeEnable, ctl.secondDebugStall, cpuHalted} = 3'h7;
		strobe(32'h3, 1);
		strobe(32'h0, 2);
		slowRun = 1'h1;
		waitst(1, 60000);
		chk(countValue, 32'h0);
		chk({28'h0, status}, 32'h3);
		strobe(32'h0, 4);
		chk({28'h0, status}, 32'h0);
		slowRun = 1'h0;
		finish_test();
	end
endmodule
bind gpt_timer gpt_timer_chk u_chk (.*);
`default_nettype wire
